//--- src/cpdpm_pkg.sv
// Package for the configuration pin decoder and shared pin multiplexer
`default_nettype none
package cpdpm_pkg;
    // ****************************************
    // Register indexes, byte address is four times the index
    // ****************************************
    localparam logic [7:0] CPDPM_IDX_REFCTL = 8'h29;
    localparam logic [7:0] CPDPM_IDX_OUT1CTL = 8'h32;
    localparam logic [7:0] CPDPM_IDX_OUT2CTL = 8'h34;
    localparam logic [7:0] CPDPM_IDX_STATUS = 8'h40;
    localparam int CPDPM_ADDR_W = 10;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int CPDPM_REF_OVR_BIT = 5;
    localparam int CPDPM_REF_SW_SEL_BIT = 0;
    localparam int CPDPM_OUT_SRC_BIT = 0;
    localparam int CPDPM_OUT_MODE_LSB = 1;
    localparam int CPDPM_ST_SERIAL_BIT = 0;
    localparam int CPDPM_ST_LOCK_BIT = 1;
    localparam int CPDPM_ST_REF_BIT = 2;
    localparam int CPDPM_ST_OUTSEL_LSB = 8;
    localparam int CPDPM_ST_INSEL_LSB = 16;
    localparam int CPDPM_ST_PINMODE_LSB = 24;
    // ****************************************
    // Widths and reset values
    // ****************************************
    localparam int CPDPM_OUT_STRAP_W = 6;
    localparam int CPDPM_IN_STRAP_W = 4;
    localparam int CPDPM_MODE_W = 3;
    localparam logic [7:0] CPDPM_REFCTL_RST = 8'h00;
    localparam logic [7:0] CPDPM_OUTCTL_RST = 8'h00;
    localparam logic [2:0] CPDPM_MODE_RST = 3'h7;
    localparam logic [5:0] CPDPM_OUT_STRAP_RST = 6'h3f;
    localparam logic [3:0] CPDPM_IN_STRAP_RST = 4'hf;
    localparam logic [3:0] CPDPM_REFPIN_RST = 4'h0;
    localparam logic [5:0] CPDPM_OUT_SERIAL_CODE = 6'h00;
    localparam logic [3:0] CPDPM_IN_SERIAL_CODE = 4'h0;
    localparam int CPDPM_OUT_PRESETS = 51;
    localparam int CPDPM_IN_PRESETS = 15;
    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [0:0] {
        CPDPM_REF_FIRST = 1'b0,
        CPDPM_REF_SECOND = 1'b1
    } cpdpm_ref_t;
    typedef enum logic [1:0] {
        CPDPM_APB_IDLE = 2'b00,
        CPDPM_APB_WAIT = 2'b01,
        CPDPM_APB_DONE = 2'b10
    } cpdpm_apb_t;
endpackage
`default_nettype wire

//--- src/cpdpm_top.sv
// Configuration pin decoder, shared serial pin multiplexer and APB registers
//
// Notes on behaviour
// - Six output straps pick one of 51 pairs
// - Output straps all low enable serial programming
// - Four input straps pick one of 15 references
// - Input straps all low enable serial programming
// - Select pin low first, high second, if present
// - Override bit 0x29[5] ignores select pin
// - Shared pin one: mode bit2 or chip select
// - Three mode bits choose one of eight configurations
// - Shared pin two: mode bit1 or serial clock
// - Shared pin three: mode bit0 or bidirectional data
// - Reset low returns control logic to defaults
// - Lock output follows PLL locked three clocks later
// - Ground strap reads zero, open reads one
`default_nettype none
module cpdpm_top
    import cpdpm_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [CPDPM_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Strap and control pins
    input wire logic [CPDPM_OUT_STRAP_W-1:0] out_freq_strap,
    input wire logic [CPDPM_IN_STRAP_W-1:0] in_freq_strap,
    input wire logic ref_select_pin,
    input wire logic first_ref_present,
    input wire logic second_ref_present,
    input wire logic pll_locked,
    // Shared pins
    input wire logic shared_pin1_in,
    input wire logic shared_pin2_in,
    input wire logic shared_pin3_in,
    output logic shared_pin3_out,
    output logic shared_pin3_oe,
    // Serial port core side
    input wire logic serial_sdo,
    input wire logic serial_sdo_en,
    output logic serial_cs_n,
    output logic serial_sclk,
    output logic serial_sdi,
    // Decoded results
    output logic serial_mode,
    output logic [CPDPM_OUT_STRAP_W-1:0] out_pair_sel,
    output logic [CPDPM_IN_STRAP_W-1:0] in_freq_sel,
    output logic [CPDPM_MODE_W-1:0] first_clock_out_mode,
    output logic [CPDPM_MODE_W-1:0] second_clock_out_mode,
    output logic active_ref,
    output logic lock_status
);
    // ****************************************
    // Input synchronisers
    // ****************************************
    localparam int SYNC_W = CPDPM_OUT_STRAP_W + CPDPM_IN_STRAP_W + 7;
    // Straps and shared pins start at their open level, so no false serial mode
    localparam logic [SYNC_W-1:0] SYNC_RST = {CPDPM_OUT_STRAP_RST, CPDPM_IN_STRAP_RST,
        CPDPM_REFPIN_RST, CPDPM_MODE_RST};
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic [SYNC_W-1:0] sync_raw;
    assign sync_raw = {out_freq_strap, in_freq_strap, ref_select_pin, first_ref_present,
        second_ref_present, pll_locked, shared_pin1_in, shared_pin2_in, shared_pin3_in};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= SYNC_RST;
            sync2_reg <= SYNC_RST;
        end else begin
            sync1_reg <= sync_raw;
            sync2_reg <= sync1_reg;
        end
    end
    logic [CPDPM_OUT_STRAP_W-1:0] out_strap_s;
    logic [CPDPM_IN_STRAP_W-1:0] in_strap_s;
    logic sel_pin_s, ref1_ok_s, ref2_ok_s, locked_s, pin1_s, pin2_s, pin3_s;
    // Ground reads zero, open reads one: levels used as they stand
    assign {out_strap_s, in_strap_s, sel_pin_s, ref1_ok_s, ref2_ok_s, locked_s,
        pin1_s, pin2_s, pin3_s} = sync2_reg;

    // ****************************************
    // Serial mode decision
    // ****************************************
    logic serial_next;
    assign serial_next = (out_strap_s == CPDPM_OUT_SERIAL_CODE)
        || (in_strap_s == CPDPM_IN_SERIAL_CODE);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_mode <= 1'b0;
            out_pair_sel <= CPDPM_OUT_STRAP_RST;
            in_freq_sel <= CPDPM_IN_STRAP_RST;
        end else begin
            serial_mode <= serial_next;
            out_pair_sel <= out_strap_s;
            in_freq_sel <= in_strap_s;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] refctl_reg;
    logic [7:0] out1ctl_reg;
    logic [7:0] out2ctl_reg;
    logic [CPDPM_MODE_W-1:0] pin_mode_reg;
    cpdpm_apb_t apb_state_reg;
    logic [7:0] idx;
    logic idx_ok, wr_fire;
    assign idx = paddr[9:2];
    assign idx_ok = (paddr[1:0] == 2'h0) && (idx == CPDPM_IDX_REFCTL || idx == CPDPM_IDX_OUT1CTL
        || idx == CPDPM_IDX_OUT2CTL || idx == CPDPM_IDX_STATUS);
    assign wr_fire = psel && penable && pready && pwrite && idx_ok;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refctl_reg <= CPDPM_REFCTL_RST;
            out1ctl_reg <= CPDPM_OUTCTL_RST;
            out2ctl_reg <= CPDPM_OUTCTL_RST;
        end else if (wr_fire) begin
            case (idx)
                CPDPM_IDX_REFCTL: begin
                    refctl_reg <= pwdata[7:0];
                end
                CPDPM_IDX_OUT1CTL: begin
                    out1ctl_reg <= pwdata[7:0];
                end
                CPDPM_IDX_OUT2CTL: begin
                    out2ctl_reg <= pwdata[7:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // APB handshake, one wait state
    // ****************************************
    logic [31:0] status_word;
    always_comb begin
        status_word = 32'h0;
        status_word[CPDPM_ST_SERIAL_BIT] = serial_mode;
        status_word[CPDPM_ST_LOCK_BIT] = lock_status;
        status_word[CPDPM_ST_REF_BIT] = active_ref;
        status_word[CPDPM_ST_OUTSEL_LSB +: CPDPM_OUT_STRAP_W] = out_pair_sel;
        status_word[CPDPM_ST_INSEL_LSB +: CPDPM_IN_STRAP_W] = in_freq_sel;
        status_word[CPDPM_ST_PINMODE_LSB +: CPDPM_MODE_W] = pin_mode_reg;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            apb_state_reg <= CPDPM_APB_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            case (apb_state_reg)
                CPDPM_APB_IDLE: begin
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                    if (psel && !penable) begin
                        apb_state_reg <= CPDPM_APB_WAIT;
                    end
                end
                CPDPM_APB_WAIT: begin
                    pready <= 1'b1;
                    pslverr <= !idx_ok;
                    apb_state_reg <= CPDPM_APB_DONE;
                    prdata <= 32'h0;
                    if (!pwrite && idx_ok) begin
                        case (idx)
                            CPDPM_IDX_REFCTL: prdata <= {24'h0, refctl_reg};
                            CPDPM_IDX_OUT1CTL: prdata <= {24'h0, out1ctl_reg};
                            CPDPM_IDX_OUT2CTL: prdata <= {24'h0, out2ctl_reg};
                            default: prdata <= status_word;
                        endcase
                    end
                end
                CPDPM_APB_DONE: begin
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                    apb_state_reg <= CPDPM_APB_IDLE;
                end
                default: begin
                    apb_state_reg <= CPDPM_APB_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Shared pin multiplexer
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_mode_reg <= CPDPM_MODE_RST;
            serial_cs_n <= 1'b1;
            serial_sclk <= 1'b0;
            serial_sdi <= 1'b0;
            shared_pin3_out <= 1'b0;
            shared_pin3_oe <= 1'b0;
        end else if (serial_next) begin
            serial_cs_n <= pin1_s;
            serial_sclk <= pin2_s;
            serial_sdi <= pin3_s;
            shared_pin3_out <= serial_sdo;
            shared_pin3_oe <= serial_sdo_en && !pin1_s;
        end else begin
            pin_mode_reg <= {pin1_s, pin2_s, pin3_s};
            serial_cs_n <= 1'b1;
            serial_sclk <= 1'b0;
            serial_sdi <= 1'b0;
            shared_pin3_out <= 1'b0;
            shared_pin3_oe <= 1'b0;
        end
    end

    // Output driver mode, registers take over once enabled in serial mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_clock_out_mode <= CPDPM_MODE_RST;
            second_clock_out_mode <= CPDPM_MODE_RST;
        end else begin
            if (serial_mode && out1ctl_reg[CPDPM_OUT_SRC_BIT]) begin
                first_clock_out_mode <= out1ctl_reg[CPDPM_OUT_MODE_LSB +: CPDPM_MODE_W];
            end else begin
                first_clock_out_mode <= pin_mode_reg;
            end
            if (serial_mode && out2ctl_reg[CPDPM_OUT_SRC_BIT]) begin
                second_clock_out_mode <= out2ctl_reg[CPDPM_OUT_MODE_LSB +: CPDPM_MODE_W];
            end else begin
                second_clock_out_mode <= pin_mode_reg;
            end
        end
    end

    // ****************************************
    // Reference selection and lock
    // ****************************************
    logic want_second, want_ok;
    assign want_second = refctl_reg[CPDPM_REF_OVR_BIT] ? refctl_reg[CPDPM_REF_SW_SEL_BIT]
        : sel_pin_s;
    assign want_ok = want_second ? ref2_ok_s : ref1_ok_s;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_ref <= CPDPM_REF_FIRST;
            lock_status <= 1'b0;
        end else begin
            if (want_ok) begin
                active_ref <= want_second;
            end
            lock_status <= locked_s;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_SERIAL_OUT_ZERO: assert property (
        out_strap_s == CPDPM_OUT_SERIAL_CODE |=> serial_mode)
        else $error("Zero output strap did not give serial mode");
    AST_SERIAL_IN_ZERO: assert property (
        in_strap_s == CPDPM_IN_SERIAL_CODE |=> serial_mode)
        else $error("Zero input strap did not give serial mode");
    AST_PRESET_MODE: assert property (
        !serial_next |=> !serial_mode && serial_cs_n && !shared_pin3_oe)
        else $error("Serial function active outside serial mode");
    AST_OUT_SEL: assert property (
        ##1 out_pair_sel == $past(out_strap_s))
        else $error("Output pair select lost the strap value");
    AST_IN_SEL: assert property (
        ##1 in_freq_sel == $past(in_strap_s))
        else $error("Input frequency select lost the strap value");
    AST_CS_FOLLOW: assert property (
        serial_next |=> serial_cs_n == $past(pin1_s))
        else $error("Chip select does not follow the shared pin");
    AST_SCLK_FOLLOW: assert property (
        serial_next |=> serial_sclk == $past(pin2_s))
        else $error("Serial clock does not follow the shared pin");
    AST_SDIO_DRIVE: assert property (
        shared_pin3_oe |-> $past(serial_next) && $past(serial_sdo_en))
        else $error("Data pin driven without request in serial mode");
    AST_MODE_PIN: assert property (
        !serial_next ##1 !serial_mode |=> first_clock_out_mode == $past(pin_mode_reg))
        else $error("Output mode does not follow mode pins");
    AST_REF_OVR: assert property (
        refctl_reg[CPDPM_REF_OVR_BIT] && $changed(sel_pin_s)
        && $stable(refctl_reg) && $stable(ref1_ok_s) && $stable(ref2_ok_s)
        |=> $stable(active_ref))
        else $error("Select pin acted while overridden");
    AST_REF_PIN: assert property (
        !refctl_reg[CPDPM_REF_OVR_BIT] && sel_pin_s && ref2_ok_s |=> active_ref)
        else $error("Second reference not chosen");
    AST_LOCK: assert property (
        locked_s |=> lock_status)
        else $error("Lock output stayed low while locked");
    AST_UNLOCK: assert property (
        !locked_s |=> !lock_status)
        else $error("Lock output stayed high while unlocked");
endmodule
`default_nettype wire

//--- verification/cpdpm_host_model.sv
// Board strap and serial host pin model
`default_nettype none
module cpdpm_host_model (
    // Clock
    input wire logic pclk,
    // Host requests
    input wire logic host_en,
    input wire logic [2:0] host_pins,
    // Device data pin drive
    input wire logic pin3_out,
    input wire logic pin3_oe,
    // Resolved pins
    output logic pin1,
    output logic pin2,
    output logic pin3
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last = 1'b0;
    assign pin1 = host_pins[2];
    assign pin2 = host_pins[1];
    // Released data line shows the inverse of its last value
    assign pin3 = pin3_oe ? pin3_out : (host_en ? host_pins[0] : ~last);
    always @(posedge pclk) begin
        last <= pin3;
    end
endmodule
`default_nettype wire

//--- verification/tb_config_pin_decode_and_port_mux.sv
// Testbench for the configuration pin decoder and shared pin multiplexer
`default_nettype none
module tb_config_pin_decode_and_port_mux;
    import cpdpm_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0, prdata, rq;
    logic pready, pslverr, re;
    logic [5:0] ostrap = 6'h01, opair;
    logic [3:0] istrap = 4'h1, isel;
    logic rsel = 1'b0, rp1 = 1'b1, rp2 = 1'b1, lock = 1'b0, sdo = 1'b0, sdo_en = 1'b0;
    logic host_en = 1'b1, p1, p2, p3, p3o, p3oe, cs_n, sclk, sdi, smode, aref, lst;
    logic [2:0] hp = 3'h5, m1, m2;
    int error_cnt = 0, n_checks = 0, cycles = 0;
    // ****************************************
    // Clock, models and device
    // ****************************************
    always #20 pclk = ~pclk;
    cpdpm_host_model host (.pclk(pclk), .host_en(host_en), .host_pins(hp), .pin3_out(p3o),
        .pin3_oe(p3oe), .pin1(p1), .pin2(p2), .pin3(p3));
    cpdpm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .out_freq_strap(ostrap), .in_freq_strap(istrap),
        .ref_select_pin(rsel), .first_ref_present(rp1), .second_ref_present(rp2),
        .pll_locked(lock), .shared_pin1_in(p1), .shared_pin2_in(p2), .shared_pin3_in(p3),
        .shared_pin3_out(p3o), .shared_pin3_oe(p3oe), .serial_sdo(sdo),
        .serial_sdo_en(sdo_en), .serial_cs_n(cs_n), .serial_sclk(sclk), .serial_sdi(sdi),
        .serial_mode(smode), .out_pair_sel(opair), .in_freq_sel(isel),
        .first_clock_out_mode(m1), .second_clock_out_mode(m2), .active_ref(aref),
        .lock_status(lst));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic stop_test();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            stop_test();
        end
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [5:0] o;
        logic [3:0] i;
        logic [2:0] m;
        rq = $urandom(32'hf245);
        cyc(10);
        chk({smode, m1, cs_n, sclk, sdi, pready}, 32'h78);
        cyc(10);
        presetn <= 1'b1;
        for (int k = 0; k < 12; k++) begin
            o = (k == 0) ? 6'h00 : 6'($urandom);
            i = (k == 1) ? 4'h0 : 4'($urandom);
            ostrap <= o;
            istrap <= i;
            cyc(5);
            chk(opair, o);
            chk(isel, i);
            chk(smode, (o == 6'h00) || (i == 4'h0));
        end
        ostrap <= 6'h01;
        istrap <= 4'h1;
        sdo_en <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            hp <= 3'(k);
            cyc(5);
            chk({m1, m2}, {3'(k), 3'(k)});
            chk({cs_n, sclk, sdi, p3oe}, 4'h8);
        end
        sdo_en <= 1'b0;
        ostrap <= 6'h00;
        for (int k = 0; k < 8; k++) begin
            hp <= 3'($urandom);
            cyc(5);
            chk({cs_n, sclk, sdi}, hp);
        end
        host_en <= 1'b0;
        hp <= 3'h0;
        sdo_en <= 1'b1;
        sdo <= 1'b1;
        cyc(5);
        chk({p3oe, p3o}, 2'h3);
        sdo <= 1'b0;
        cyc(3);
        chk({p3oe, p3o}, 2'h2);
        hp <= 3'h4;
        cyc(5);
        chk(p3oe, 1'b0);
        host_en <= 1'b1;
        m = 3'($urandom);
        apb(1'b1, {CPDPM_IDX_OUT1CTL, 2'b00}, {28'h0, m, 1'b1});
        apb(1'b1, {CPDPM_IDX_OUT2CTL, 2'b00}, {28'h0, ~m, 1'b1});
        cyc(3);
        chk({m1, m2}, {m, ~m});
        apb(1'b0, {CPDPM_IDX_OUT1CTL, 2'b00}, 32'h0);
        chk(rq, {28'h0, m, 1'b1});
        chk(re, 1'b0);
        apb(1'b0, 10'h3fc, 32'h0);
        chk(rq, 32'h0);
        chk(re, 1'b1);
        apb(1'b0, {CPDPM_IDX_STATUS, 2'b00}, 32'h0);
        chk(rq[1:0], {lock, 1'b1});
        rsel <= 1'b1;
        cyc(5);
        chk(aref, 1'b1);
        rsel <= 1'b0;
        cyc(5);
        chk(aref, 1'b0);
        rp2 <= 1'b0;
        rsel <= 1'b1;
        cyc(5);
        chk(aref, 1'b0);
        rp2 <= 1'b1;
        apb(1'b1, {CPDPM_IDX_REFCTL, 2'b00}, 32'h20);
        cyc(5);
        chk(aref, 1'b0);
        apb(1'b1, {CPDPM_IDX_REFCTL, 2'b00}, 32'h21);
        rsel <= 1'b0;
        cyc(5);
        chk(aref, 1'b1);
        for (int k = 0; k < 4; k++) begin
            lock <= ~lock;
            cyc(5);
            chk(lst, lock);
        end
        presetn <= 1'b0;
        cyc(2);
        chk({smode, m1, cs_n, aref, lst}, 7'h3c);
        presetn <= 1'b1;
        apb(1'b0, {CPDPM_IDX_REFCTL, 2'b00}, 32'h0);
        chk(rq, 32'h0);
        stop_test();
    end
endmodule
`default_nettype wire
